// >>> shared/tsd_defs.vh
// Register map, field positions, reset values and scaling for the touch decision logic
`ifndef TSD_DEFS_VH
`define TSD_DEFS_VH
`define TSD_ADDR_TOUCH_STAT  8'h01
`define TSD_ADDR_PROX_STAT   8'h02
`define TSD_ADDR_THRESH0     8'h28
`define TSD_ADDR_THRESH_CMB  8'h30
`define TSD_ADDR_OP          8'h31
`define TSD_ADDR_MODE        8'h32
`define TSD_ADDR_DEBOUNCE    8'h33
`define TSD_ADDR_NEG_THRESH  8'h34
`define TSD_OP_AUTO_OFF      7
`define TSD_OP_PROX_BL0      6
`define TSD_OP_PROX_CMB      5
`define TSD_MODE_FILT_HI     7
`define TSD_MODE_FILT_LO     5
`define TSD_MODE_ALL_TOUCH   4
`define TSD_MODE_GAIN_HI     3
`define TSD_MODE_GAIN_LO     2
`define TSD_MODE_REP_HI      1
`define TSD_MODE_REP_LO      0
`define TSD_DB_NEAR_LO       6
`define TSD_DB_FAR_LO        4
`define TSD_DB_PRESS_LO      2
`define TSD_DB_REL_LO        0
`define TSD_RST_OP           8'h14
`define TSD_RST_MODE         8'h00
`define TSD_RST_DEBOUNCE     8'h00
`define TSD_RST_NEG_THRESH   8'h00
`define TSD_RST_THRESH       8'h10
`define TSD_THRESH_SHIFT     4
`define TSD_NEG_SHIFT        7
`define TSD_REP_SINGLE       2'h0
`define TSD_REP_STRONG       2'h1
`define TSD_REP_DOUBLE       2'h2
`define TSD_REP_DOUBLE_LED   2'h3
`define TSD_CMB_CHAN         4'h8
`endif

// >>> src/tsd_touch_decide.v
// Touch and proximity decision logic: filter, gain, debounce, drift and report
//
// Summary of operation
// - Operation bit 7 low enables automatic drift compensation, high disables it.
// - Operation bit 6 makes button line zero a proximity sensor instead of a button.
// - Operation bit 5 enables the combined channels as a proximity sensor.
// - Mode bits 7:5 pick filtering off or coefficient 1-1/2 to 1-1/128.
// - Mode bit 4 high reports every touch in touch status, else report mode.
// - Mode bits 3:2 apply gain 1, 2, 4 or 8, shrinking range alike.
// - Gained delta beyond range saturates to the limit, never wraps.
// - Report mode 00 reports only the first detected touch.
// - Report mode 01 reports only the strongest detected touch.
// - Report mode 10 reports first touch per LED engine.
// - Report mode 11 reports first two per engine; second switches without fade.
// - With proximity enabled engine 1 serves proximity; modes use engine 2 only.
// - Near debounce bits 7:6 need 1, 2, 4 or 8 true samples.
// - Far debounce bits 5:4 need 1, 2, 4 or 8 false samples.
// - Press debounce bits 3:2 need 1, 2, 4 or 8 true samples.
// - Release debounce bits 1:0 need 1, 2, 4 or 8 false samples.
// - Negative compensation fires when delta falls to or below minus register value times 128.
// - Detection threshold per line is its eight-bit value times 16.
// - Negative compensation needs 1, 2, 4 or 8 samples below threshold.
`timescale 1ns/1ns
`include "tsd_defs.vh"
module tsd_touch_decide #(
  parameter DATA_W    = 16,
  parameter DELTA_LIM = 16'h7fff
) (
  // Clock and reset
  input  wire              mclk,
  input  wire              rst_b,
  // Register port
  input  wire [7:0]        reg_addr,
  input  wire [7:0]        reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [7:0]        reg_rdata,
  output reg               reg_rvalid,
  // Raw samples, channel 8 is the combined channel
  input  wire              smp_valid,
  input  wire [3:0]        smp_chan,
  input  wire [DATA_W-1:0] smp_raw,
  // Static configuration from neighbouring logic
  input  wire [7:0]        led_engine_two,
  input  wire [1:0]        neg_debounce_sel,
  // Results
  output reg  [7:0]        touch_status,
  output reg  [7:0]        prox_status,
  output reg  [7:0]        led_on,
  output reg  [7:0]        led_no_fade,
  output reg               prox_led_on,
  output reg               drift_comp,
  output reg  [3:0]        drift_chan
);

  reg [7:0]        op_q;
  reg [7:0]        mode_q;
  reg [7:0]        deb_q;
  reg [7:0]        neg_thr_q;
  reg [7:0]        thr_q     [0:8];
  reg [DATA_W-1:0] useful_q  [0:8];
  reg [DATA_W-1:0] avg_q     [0:8];
  reg [3:0]        cnt_q     [0:8];
  reg [3:0]        ncnt_q    [0:8];
  reg [15:0]       strength_q [0:7];
  reg [8:0]        init_q;
  reg [8:0]        det_q;
  reg [7:0]        rep_q;
  reg [7:0]        fast_q;
  integer          i;
  integer          j;

  wire       auto_on  = ~op_q[`TSD_OP_AUTO_OFF];
  wire       prox0    = op_q[`TSD_OP_PROX_BL0];
  wire       prox_cmb = op_q[`TSD_OP_PROX_CMB];
  wire       prox_any = prox0 | prox_cmb;
  wire [2:0] filt_k   = mode_q[`TSD_MODE_FILT_HI:`TSD_MODE_FILT_LO];
  wire [1:0] gain_k   = mode_q[`TSD_MODE_GAIN_HI:`TSD_MODE_GAIN_LO];
  wire [1:0] rep_mode = mode_q[`TSD_MODE_REP_HI:`TSD_MODE_REP_LO];
  wire       ch_ok    = (smp_chan < 4'h9);
  wire [3:0] ch       = ch_ok ? smp_chan : 4'h0;
  // Combined channel and a proximity line 0 take the near/far timing
  wire       is_prox  = (ch == `TSD_CMB_CHAN) | ((ch == 4'h0) & prox0);

  // Sample datapath
  reg  signed [DATA_W+1:0] diff;
  reg  signed [DATA_W+1:0] step;
  reg  [DATA_W-1:0]        useful_n;
  reg  signed [DATA_W+1:0] delta;
  reg  signed [DATA_W+4:0] gained;
  reg  signed [DATA_W+4:0] sat;
  reg                      det_n;
  reg                      below;
  reg  [1:0]               db_code;
  reg  [3:0]               need;
  reg  [3:0]               nneed;

  always @* begin
    diff = $signed({2'b00, smp_raw}) - $signed({2'b00, useful_q[ch]});
    // Shift kept apart so it stays signed and a falling input pulls down
    step = diff >>> filt_k;
    if (!init_q[ch] || filt_k == 3'h0) begin
      useful_n = smp_raw;
    end else begin
      useful_n = useful_q[ch] + step[DATA_W-1:0];
    end
    delta  = $signed({2'b00, useful_n}) - $signed({2'b00, avg_q[ch]});
    gained = $signed({{3{delta[DATA_W+1]}}, delta}) <<< gain_k;
    if (gained > $signed({5'h00, DELTA_LIM})) begin
      sat = $signed({5'h00, DELTA_LIM});
    end else if (gained < -$signed({5'h00, DELTA_LIM})) begin
      sat = -$signed({5'h00, DELTA_LIM});
    end else begin
      sat = gained;
    end
    det_n = init_q[ch] &&
            (sat >= $signed({9'h000, thr_q[ch], {`TSD_THRESH_SHIFT{1'b0}}}));
    below = init_q[ch] &&
            (delta <= -$signed({3'h0, neg_thr_q, {`TSD_NEG_SHIFT{1'b0}}}));
    if (is_prox) begin
      db_code = det_q[ch] ? deb_q[`TSD_DB_FAR_LO+1:`TSD_DB_FAR_LO]
                          : deb_q[`TSD_DB_NEAR_LO+1:`TSD_DB_NEAR_LO];
    end else begin
      db_code = det_q[ch] ? deb_q[`TSD_DB_REL_LO+1:`TSD_DB_REL_LO]
                          : deb_q[`TSD_DB_PRESS_LO+1:`TSD_DB_PRESS_LO];
    end
    need  = 4'h1 << db_code;
    nneed = 4'h1 << neg_debounce_sel;
  end

  // Eligible buttons; a proximity line 0 is never a button
  wire [7:0] buttons = det_q[7:0] & ~{7'h00, prox0};
  // Engine 1 belongs to proximity while it is enabled
  wire [7:0] elig    = prox_any ? (buttons & led_engine_two) : buttons;

  function [7:0] lowest;
    input [7:0] x;
    begin
      lowest = x & (~x + 8'h01);
    end
  endfunction

  function [1:0] popcap;
    input [7:0] x;
    begin
      popcap = (x == 8'h00) ? 2'h0 : (((x & (x - 8'h01)) == 8'h00) ? 2'h1 : 2'h2);
    end
  endfunction

  // Report selection
  reg [7:0] rep_n;
  reg [7:0] fast_n;
  reg [7:0] grp;
  reg [7:0] keep;
  reg [7:0] pick;
  reg [15:0] best;
  reg [1:0]  g;

  always @* begin
    rep_n  = 8'h00;
    fast_n = 8'h00;
    grp    = 8'h00;
    keep   = 8'h00;
    pick   = 8'h00;
    best   = 16'h0000;
    g      = 2'h0;
    case (rep_mode)
      `TSD_REP_SINGLE: begin
        keep  = rep_q & elig;
        // A pair left from another mode collapses to one
        rep_n = (keep != 8'h00) ? lowest(keep) : lowest(elig);
      end
      `TSD_REP_STRONG: begin
        for (j = 0; j < 8; j = j + 1) begin
          if (elig[j] && (pick == 8'h00 || strength_q[j] > best)) begin
            pick = 8'h01 << j;
            best = strength_q[j];
          end
        end
        rep_n = pick;
      end
      `TSD_REP_DOUBLE, `TSD_REP_DOUBLE_LED: begin
        for (g = 2'h0; g < 2'h2; g = g + 2'h1) begin
          grp  = elig & (g[0] ? led_engine_two : ~led_engine_two);
          keep = rep_q & grp;
          if (rep_mode == `TSD_REP_DOUBLE) begin
            if (keep == 8'h00) begin
              keep = lowest(grp);
            end
            keep = lowest(keep);
          end else begin
            if (popcap(keep) == 2'h2) begin
              keep = lowest(keep) | lowest(keep & ~lowest(keep));
            end
            if (popcap(keep) == 2'h0) begin
              keep = lowest(grp);
            end
            if (popcap(keep) == 2'h1) begin
              keep = keep | lowest(grp & ~keep);
            end
            // Of the pair, the lowest-numbered line already held fades; the other goes without fading
            pick = (rep_q & keep) != 8'h00 ? lowest(rep_q & keep) : lowest(keep);
            if (popcap(keep) == 2'h2) begin
              fast_n = fast_n | (keep & ~pick);
            end
          end
          rep_n = rep_n | keep;
        end
      end
      default: rep_n = 8'h00;
    endcase
  end

  // Registers and sample state
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      op_q       <= `TSD_RST_OP;
      mode_q     <= `TSD_RST_MODE;
      deb_q      <= `TSD_RST_DEBOUNCE;
      neg_thr_q  <= `TSD_RST_NEG_THRESH;
      init_q     <= 9'h000;
      det_q      <= 9'h000;
      rep_q      <= 8'h00;
      fast_q     <= 8'h00;
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
      drift_comp <= 1'b0;
      drift_chan <= 4'h0;
      for (i = 0; i < 9; i = i + 1) begin
        thr_q[i]    <= `TSD_RST_THRESH;
        useful_q[i] <= {DATA_W{1'b0}};
        avg_q[i]    <= {DATA_W{1'b0}};
        cnt_q[i]    <= 4'h0;
        ncnt_q[i]   <= 4'h0;
      end
      for (i = 0; i < 8; i = i + 1) begin
        strength_q[i] <= 16'h0000;
      end
    end else begin
      reg_rvalid <= reg_rd;
      drift_comp <= 1'b0;
      rep_q      <= rep_n;
      fast_q     <= fast_n;
      if (reg_wr) begin
        case (reg_addr)
          `TSD_ADDR_OP:         op_q      <= reg_wdata;   // Low bits kept as written
          `TSD_ADDR_MODE:       mode_q    <= reg_wdata;
          `TSD_ADDR_DEBOUNCE:   deb_q     <= reg_wdata;
          `TSD_ADDR_NEG_THRESH: neg_thr_q <= reg_wdata;
          default: begin
            if (reg_addr >= `TSD_ADDR_THRESH0 && reg_addr <= `TSD_ADDR_THRESH_CMB) begin
              thr_q[reg_addr[3:0] - 4'h8] <= reg_wdata;
            end
          end
        endcase
      end
      if (reg_rd) begin
        case (reg_addr)
          `TSD_ADDR_TOUCH_STAT: reg_rdata <= touch_status;
          `TSD_ADDR_PROX_STAT:  reg_rdata <= prox_status;
          `TSD_ADDR_OP:         reg_rdata <= op_q;
          `TSD_ADDR_MODE:       reg_rdata <= mode_q;
          `TSD_ADDR_DEBOUNCE:   reg_rdata <= deb_q;
          `TSD_ADDR_NEG_THRESH: reg_rdata <= neg_thr_q;
          default: begin
            if (reg_addr >= `TSD_ADDR_THRESH0 && reg_addr <= `TSD_ADDR_THRESH_CMB) begin
              reg_rdata <= thr_q[reg_addr[3:0] - 4'h8];
            end else begin
              reg_rdata <= 8'h00;
            end
          end
        endcase
      end
      if (smp_valid && ch_ok) begin
        init_q[ch]   <= 1'b1;
        useful_q[ch] <= useful_n;
        // First sample seeds the baseline so nothing reports at start-up
        if (!init_q[ch]) begin
          avg_q[ch] <= smp_raw;
        end
        if (ch != `TSD_CMB_CHAN) begin
          // Negative deltas count as no strength, not as huge ones
          strength_q[ch[2:0]] <= sat[DATA_W+4] ? 16'h0000 : sat[15:0];
        end
        if (det_n == det_q[ch]) begin
          cnt_q[ch] <= 4'h0;
        end else if (cnt_q[ch] + 4'h1 >= need) begin
          det_q[ch] <= det_n;
          cnt_q[ch] <= 4'h0;
        end else begin
          cnt_q[ch] <= cnt_q[ch] + 4'h1;
        end
        if (!below || !auto_on) begin
          ncnt_q[ch] <= 4'h0;
        end else if (ncnt_q[ch] + 4'h1 >= nneed) begin
          avg_q[ch]  <= useful_n;
          ncnt_q[ch] <= 4'h0;
          drift_comp <= 1'b1;
          drift_chan <= ch;
        end else begin
          ncnt_q[ch] <= ncnt_q[ch] + 4'h1;
        end
      end
    end
  end

  // Outputs, all registered
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      touch_status <= 8'h00;
      prox_status  <= 8'h00;
      led_on       <= 8'h00;
      led_no_fade  <= 8'h00;
      prox_led_on  <= 1'b0;
    end else begin
      touch_status <= mode_q[`TSD_MODE_ALL_TOUCH] ? buttons : rep_n;
      prox_status  <= {6'h00, prox_cmb & det_q[8], prox0 & det_q[0]};
      led_on       <= rep_n;
      led_no_fade  <= fast_n;
      prox_led_on  <= (prox_cmb & det_q[8]) | (prox0 & det_q[0]);
    end
  end

endmodule

// >>> test/tsd_host.sv
// Host model driving the register port
`timescale 1ns/1ns
module tsd_host (
  // Clock
  input  wire       mclk,
  // Register port
  output reg  [7:0] reg_addr,
  output reg  [7:0] reg_wdata,
  output reg        reg_wr,
  output reg        reg_rd,
  input  wire [7:0] reg_rdata,
  input  wire       reg_rvalid
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= (a == 8'h31) ? {d[7:5], 5'h14} : d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
    end
  endtask
  // Answer is registered, so it is stable through its cycle
  task rd(input [7:0] a, output [7:0] d, output ok);
    integer n;
    begin
      ok = 1'b0;
      d = 8'h00;
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      for (n = 0; n < 4 && !ok; n = n + 1) begin
        #1;
        ok = reg_rvalid;
        d = reg_rdata;
        if (!ok) @(posedge mclk);
      end
    end
  endtask
endmodule

// >>> test/tsd_monitor.sv
// Checker bound to the touch decision logic
`timescale 1ns/1ns
module tsd_monitor (
  // Clock and reset
  input wire       mclk,
  input wire       rst_b,
  // Register writes and samples
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       smp_valid,
  // Results
  input wire [7:0] touch_status,
  input wire [7:0] prox_status,
  input wire [7:0] led_on,
  input wire [7:0] led_no_fade,
  input wire       prox_led_on,
  input wire       drift_comp
);
  reg  [7:0] op_q;
  reg  [7:0] mode_q;
  reg  [2:0] age_q;
  wire       calm = (age_q == 3'h4);
  // Outputs lag a config write by a few cycles
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      op_q <= 8'h14;
      mode_q <= 8'h00;
      age_q <= 3'h0;
    end else begin
      if (reg_wr && reg_addr == 8'h31) op_q <= reg_wdata;
      if (reg_wr && reg_addr == 8'h32) mode_q <= reg_wdata;
      if (reg_wr) age_q <= 3'h0;
      else if (!calm) age_q <= age_q + 3'h1;
    end
  end
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  drift_off_a: assert property (op_q[7] && $past(op_q[7]) |-> !drift_comp)
    else $error("compensation while disabled");
  drift_cause_a: assert property (drift_comp |-> $past(smp_valid) || $past(smp_valid, 2))
    else $error("compensation without sample");
  single_led_a: assert property (calm && !mode_q[1] |-> $countones(led_on) <= 1)
    else $error("more than one led in single mode");
  double_led_a: assert property (calm && mode_q[1:0] == 2'h2 |-> $countones(led_on) <= 2)
    else $error("more than two leds in double mode");
  pair_led_a: assert property (calm && mode_q[1:0] == 2'h3 |-> $countones(led_on) <= 4)
    else $error("more than four leds in pair mode");
  no_fade_a: assert property (calm && mode_q[1:0] != 2'h3 |-> led_no_fade == 8'h00)
    else $error("no-fade led outside pair mode");
  status_match_a: assert property (calm && !mode_q[4] |-> touch_status == led_on)
    else $error("status differs from led report");
  all_touch_a: assert property (calm && mode_q[4] |-> (led_on & ~touch_status) == 8'h00)
    else $error("reported led not in status");
  prox_off_a: assert property (calm && op_q[6:5] == 2'h0 |-> prox_status == 8'h00)
    else $error("proximity while disabled");
  prox_led_a: assert property (prox_led_on == (|prox_status))
    else $error("proximity led without proximity");
endmodule
bind tsd_touch_decide tsd_monitor mon (
  .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .smp_valid(smp_valid), .touch_status(touch_status),
  .prox_status(prox_status), .led_on(led_on), .led_no_fade(led_no_fade),
  .prox_led_on(prox_led_on), .drift_comp(drift_comp)
);

// >>> test/testbench.sv
// Self-checking bench for the touch decision logic
`timescale 1ns/1ns
module testbench;
  reg         mclk;
  reg         rst_b;
  reg         smp_valid;
  reg  [3:0]  smp_chan;
  reg  [15:0] smp_raw;
  reg  [7:0]  led_engine_two;
  reg  [1:0]  neg_debounce_sel;
  wire [7:0]  reg_addr, reg_wdata, reg_rdata;
  wire        reg_wr, reg_rd, reg_rvalid;
  wire [7:0]  touch_status, prox_status, led_on, led_no_fade;
  wire        prox_led_on, drift_comp;
  wire [3:0]  drift_chan;
  integer     miscompares, samples_checked, drift_n, i;
  tsd_touch_decide uut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .smp_valid(smp_valid), .smp_chan(smp_chan),
    .smp_raw(smp_raw), .led_engine_two(led_engine_two),
    .neg_debounce_sel(neg_debounce_sel), .touch_status(touch_status),
    .prox_status(prox_status), .led_on(led_on), .led_no_fade(led_no_fade),
    .prox_led_on(prox_led_on), .drift_comp(drift_comp), .drift_chan(drift_chan));
  tsd_host host (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  task chk(input string nm, input [15:0] seen, input [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("[ERR] %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
        $display("All tests passed");
      end else begin
        $display("Some tests failed");
      end
      $finish;
    end
  endtask
  task do_reset;
    begin
      @(posedge mclk);
      rst_b <= 1'b0;
      repeat (12) @(posedge mclk);
      rst_b <= 1'b1;
    end
  endtask
  // Status is visible one edge after the sample is taken
  task smp(input [3:0] ch, input [15:0] raw);
    begin
      @(posedge mclk);
      smp_valid <= 1'b1;
      smp_chan <= ch;
      smp_raw <= raw;
      @(posedge mclk);
      smp_valid <= 1'b0;
      @(posedge mclk);
      #1;
    end
  endtask
  task rdchk(input [7:0] a, input [7:0] e);
    reg [7:0] d;
    reg       ok;
    begin
      host.rd(a, d, ok);
      if (!ok) begin
        miscompares = miscompares + 1;
        report_and_stop;
      end
      chk("rdata", d, e);
    end
  endtask
  task t_regs;
    begin
      do_reset;
      rdchk(8'h31, 8'h14);
      rdchk(8'h32, 8'h00);
      rdchk(8'h33, 8'h00);
      rdchk(8'h34, 8'h00);
      rdchk(8'h28, 8'h10);
      rdchk(8'h00, 8'h00);
      host.wr(8'h31, 8'hff);
      host.wr(8'h34, 8'h5a);
      rdchk(8'h31, 8'hf4);
      rdchk(8'h34, 8'h5a);
    end
  endtask
  task t_debounce;
    begin
      do_reset;
      host.wr(8'h33, 8'h06);
      smp(4'h3, 16'h0400);
      smp(4'h3, 16'h0540);
      chk("touch", touch_status, 16'h0000);
      smp(4'h3, 16'h0540);
      chk("touch", touch_status, 16'h0008);
      chk("led_on", led_on, 16'h0008);
      rdchk(8'h01, 8'h08);
      for (i = 0; i < 3; i = i + 1) smp(4'h3, 16'h0400);
      chk("touch", touch_status, 16'h0008);
      smp(4'h3, 16'h0540);
      for (i = 0; i < 3; i = i + 1) smp(4'h3, 16'h0400);
      chk("touch", touch_status, 16'h0008);
      smp(4'h3, 16'h0400);
      chk("touch", touch_status, 16'h0000);
    end
  endtask
  task t_report;
    begin
      do_reset;
      led_engine_two <= 8'h22;
      smp(4'h1, 16'h0400);
      smp(4'h2, 16'h0400);
      smp(4'h5, 16'h0400);
      smp(4'h2, 16'h0540);
      smp(4'h1, 16'h0700);
      smp(4'h5, 16'h0540);
      chk("led_on", led_on, 16'h0004);
      host.wr(8'h32, 8'h10);
      smp(4'h1, 16'h0700);
      chk("touch", touch_status, 16'h0026);
      chk("led_on", led_on, 16'h0004);
      for (i = 1; i < 4; i = i + 1) begin
        host.wr(8'h32, i[7:0]);
        smp(4'h1, 16'h0700);
        chk("led_on", led_on, (i == 1) ? 16'h0002 : (i == 2) ? 16'h0006 : 16'h0026);
      end
      chk("no_fade", led_no_fade, 16'h0020);
      host.wr(8'h32, 8'h00);
      smp(4'h1, 16'h0700);
      chk("led_on", led_on, 16'h0002);
    end
  endtask
  task t_gain;
    begin
      do_reset;
      host.wr(8'h32, 8'h1c);
      smp(4'h4, 16'h0400);
      smp(4'h4, 16'h0428);
      chk("touch", touch_status, 16'h0010);
      smp(4'h6, 16'h0000);
      smp(4'h6, 16'h1000);
      chk("touch", touch_status, 16'h0050);
      do_reset;
      host.wr(8'h32, 8'h20);
      smp(4'h7, 16'h0400);
      smp(4'h7, 16'h05c0);
      chk("touch", touch_status, 16'h0000);
      smp(4'h7, 16'h05c0);
      chk("touch", touch_status, 16'h0080);
    end
  endtask
  task t_drift;
    begin
      do_reset;
      neg_debounce_sel <= 2'h1;
      host.wr(8'h34, 8'h01);
      drift_n = 0;
      smp(4'h5, 16'h0400);
      smp(4'h5, 16'h0380);
      repeat (2) @(posedge mclk);
      chk("drift_n", drift_n, 16'h0000);
      smp(4'h5, 16'h0380);
      repeat (2) @(posedge mclk);
      chk("drift_n", drift_n, 16'h0001);
      chk("drift_chan", drift_chan, 16'h0005);
      host.wr(8'h31, 8'h80);
      smp(4'h5, 16'h0300);
      smp(4'h5, 16'h0300);
      repeat (2) @(posedge mclk);
      chk("drift_n", drift_n, 16'h0001);
    end
  endtask
  task t_prox;
    begin
      do_reset;
      led_engine_two <= 8'h22;
      host.wr(8'h33, 8'h50);
      host.wr(8'h31, 8'h40);
      smp(4'h0, 16'h0400);
      smp(4'h0, 16'h0540);
      chk("prox", prox_status, 16'h0000);
      smp(4'h0, 16'h0540);
      chk("prox", prox_status, 16'h0001);
      chk("touch", touch_status, 16'h0000);
      chk("prox_led", prox_led_on, 16'h0001);
      smp(4'h0, 16'h0400);
      chk("prox", prox_status, 16'h0001);
      smp(4'h0, 16'h0400);
      chk("prox", prox_status, 16'h0000);
      smp(4'h2, 16'h0400);
      smp(4'h5, 16'h0400);
      smp(4'h2, 16'h0540);
      smp(4'h5, 16'h0540);
      chk("led_on", led_on, 16'h0020);
      host.wr(8'h31, 8'h20);
      smp(4'h8, 16'h0400);
      smp(4'h8, 16'h0540);
      smp(4'h8, 16'h0540);
      chk("prox", prox_status, 16'h0002);
    end
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (drift_comp === 1'b1) drift_n <= drift_n + 1;
  end
  initial begin
    rst_b = 1'b0;
    smp_valid = 1'b0;
    smp_chan = 4'h0;
    smp_raw = 16'h0000;
    led_engine_two = 8'h00;
    neg_debounce_sel = 2'h0;
    miscompares = 0;
    samples_checked = 0;
    drift_n = 0;
    t_regs;
    t_debounce;
    t_report;
    t_gain;
    t_drift;
    t_prox;
    report_and_stop;
  end
endmodule
